//--- fpsh_consts.vh
// constants for the flash program/status host controller
// How it works
// - program is four writes: unlock, unlock, setup, data
// - hardware reset aborts; host repeats sequence
// - poll at program address, bit 7 inverted
// - erase polling reads 0, then 1
// - two reads compare toggle; same means done
// - toggling plus timeout: recheck, then reset
// - resumed polling restarts from double read
`ifndef FPSH_CONSTS_VH
`define FPSH_CONSTS_VH
// register byte offsets
`define FPSH_REG_CTRL 32'h0000_0000
`define FPSH_REG_ADDR 32'h0000_0004
`define FPSH_REG_DATA 32'h0000_0008
`define FPSH_REG_STAT 32'h0000_000c
`define FPSH_REG_RDAT 32'h0000_0010
`define FPSH_REG_TIME 32'h0000_0014
// ctrl field positions (write 1 to start; one at a time)
`define FPSH_CTRL_PROG 0
`define FPSH_CTRL_READ 1
`define FPSH_CTRL_RST 2
`define FPSH_CTRL_SUSP 3
`define FPSH_CTRL_RESM 4
// status field positions
`define FPSH_ST_BUSY 0
`define FPSH_ST_DONE 1
`define FPSH_ST_FAIL 2
`define FPSH_ST_RDY 3
// command bytes and unlock addresses
`define FPSH_UNLOCK_A1 21'h00_0aaa
`define FPSH_UNLOCK_A2 21'h00_0555
`define FPSH_UNLOCK_D1 8'haa
`define FPSH_UNLOCK_D2 8'h55
`define FPSH_CMD_PROG 8'ha0
`define FPSH_CMD_RST 8'hf0
`define FPSH_CMD_SUSP 8'hb0
`define FPSH_CMD_RESM 8'h30
// bus cycle timing: phase length in hclk cycles
`define FPSH_PHASE_NS 100
`define FPSH_CLK_NS 20
`define FPSH_PHASE_CYC ((`FPSH_PHASE_NS + `FPSH_CLK_NS - 1) / `FPSH_CLK_NS)
// first count of a phase: phase length in cycles minus one
`define FPSH_PHASE_LAST 4'h4
// default poll read limit before giving up
`define FPSH_POLL_MAX 32'h0001_0000
// data bit positions of status
`define FPSH_BIT_POLL 7
`define FPSH_BIT_TGL1 6
`define FPSH_BIT_TOUT 5
`endif

//--- fpsh_bus_cycle.v
// one flash bus cycle: write or read with fixed phase timing
`timescale 1ns/100ps
`include "fpsh_consts.vh"
module fpsh_bus_cycle (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // request
  input wire start,
  input wire wr,
  input wire [20:0] addr,
  input wire [7:0] wdata,
  output wire done,
  output reg [7:0] rdata,
  // flash pins
  output reg [20:0] fl_addr,
  output reg fl_ce_n,
  output reg fl_we_n,
  output reg fl_oe_n,
  input wire [7:0] fl_dq_in,
  output reg [7:0] fl_dq_out,
  output reg fl_dq_oe
);
  reg [1:0] phase;
  reg [3:0] cnt;
  reg is_wr;
  wire phase_end;
  assign phase_end = (cnt == 4'd0);
  // done one cycle before the gap ends, so the next start meets a free engine
  assign done = (phase == 2'd0) && (cnt == 4'h1);
  // setup (addr), strobe low, strobe high, then chip enable high gap
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= 2'd0;
      cnt <= 4'd0;
      is_wr <= 1'b0;
      fl_addr <= 21'h00_0000;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_dq_out <= 8'h00;
      fl_dq_oe <= 1'b0;
      rdata <= 8'h00;
    end else if (phase == 2'd0) begin
      if (!phase_end) begin
        // keep chip enable high so each access is a separate cycle
        cnt <= cnt - 4'd1;
      end else if (start) begin
        phase <= 2'd1;
        cnt <= `FPSH_PHASE_LAST;
        is_wr <= wr;
        fl_addr <= addr;
        fl_ce_n <= 1'b0;
        fl_dq_out <= wdata;
        fl_dq_oe <= wr;
      end
    end else if (!phase_end) begin
      cnt <= cnt - 4'd1;
    end else if (phase == 2'd1) begin
      phase <= 2'd2;
      cnt <= `FPSH_PHASE_LAST;
      fl_we_n <= ~is_wr;
      fl_oe_n <= is_wr;
    end else if (phase == 2'd2) begin
      // command latched / data sampled on strobe rise
      phase <= 2'd3;
      cnt <= `FPSH_PHASE_LAST;
      rdata <= fl_dq_in;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
    end else begin
      phase <= 2'd0;
      cnt <= `FPSH_PHASE_LAST;
      fl_ce_n <= 1'b1;
      fl_dq_oe <= 1'b0;
    end
  end
endmodule

//--- fpsh_ctrl.v
// host controller: ahb-lite registers driving flash program and polling
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`include "fpsh_consts.vh"
module fpsh_ctrl #(
  parameter POLL_MAX = `FPSH_POLL_MAX
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // flash pins
  output wire [20:0] fl_addr,
  output wire fl_ce_n,
  output wire fl_we_n,
  output wire fl_oe_n,
  input wire [7:0] fl_dq_in,
  output wire [7:0] fl_dq_out,
  output wire fl_dq_oe,
  output reg fl_reset_n,
  input wire ready_busy_n
);
  localparam S_IDLE = 7'b000_0001;
  localparam S_SEQ = 7'b000_0010;
  localparam S_POLL1 = 7'b000_0100;
  localparam S_POLL2 = 7'b000_1000;
  localparam S_DATA = 7'b001_0000;
  localparam S_RST = 7'b010_0000;
  localparam S_HWRST = 7'b100_0000;
  reg [6:0] state;
  reg [20:0] addr_reg;
  reg [7:0] data_reg;
  reg [7:0] rdat_reg;
  reg busy, done, fail;
  reg [2:0] step;
  reg [2:0] nsteps;
  reg [7:0] first;
  reg tout_seen;
  reg [31:0] poll_cnt;
  reg [1:0] kind;
  // ahb address phase capture
  reg ph_wr;
  reg [4:0] ph_addr;
  wire take;
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_addr <= 5'h00;
    end else begin
      ph_wr <= take && hwrite;
      ph_addr <= haddr[4:0];
    end
  end
  // read data mux, registered on the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case ({27'h000_0000, haddr[4:0]})
        `FPSH_REG_ADDR: hrdata <= {11'h000, addr_reg};
        `FPSH_REG_DATA: hrdata <= {24'h00_0000, data_reg};
        `FPSH_REG_STAT: hrdata <= {28'h000_0000, ready_busy_n, fail,
                                   done, busy};
        `FPSH_REG_RDAT: hrdata <= {24'h00_0000, rdat_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
  wire ctrl_wr;
  assign ctrl_wr = ph_wr && ({27'h000_0000, ph_addr} == `FPSH_REG_CTRL);
  // bus cycle engine
  reg cyc_start, cyc_wr;
  reg [20:0] cyc_addr;
  reg [7:0] cyc_wdata;
  wire cyc_done;
  wire [7:0] cyc_rdata;
  fpsh_bus_cycle u_cyc (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(cyc_start),
    .wr(cyc_wr),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n),
    .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe)
  );
  // command sequence table per step
  always @* begin
    cyc_wr = 1'b1;
    cyc_addr = `FPSH_UNLOCK_A1;
    cyc_wdata = `FPSH_UNLOCK_D1;
    if (state == S_SEQ) begin
      case (step)
        3'd0: begin
          cyc_addr = (kind == 2'd0) ? `FPSH_UNLOCK_A1 : addr_reg;
          cyc_wdata = (kind == 2'd1) ? `FPSH_CMD_RST :
                      (kind == 2'd2) ? `FPSH_CMD_SUSP :
                      (kind == 2'd3) ? `FPSH_CMD_RESM : `FPSH_UNLOCK_D1;
        end
        3'd1: begin
          cyc_addr = `FPSH_UNLOCK_A2;
          cyc_wdata = `FPSH_UNLOCK_D2;
        end
        3'd2: cyc_wdata = `FPSH_CMD_PROG;
        default: begin
          cyc_addr = addr_reg;
          cyc_wdata = data_reg;
        end
      endcase
    end else if (state == S_RST) begin
      cyc_wdata = `FPSH_CMD_RST;
    end else begin
      // status or data read at the chosen address
      cyc_wr = 1'b0;
      cyc_addr = addr_reg;
    end
  end
  wire tgl_same;
  assign tgl_same = (first[`FPSH_BIT_TGL1] == cyc_rdata[`FPSH_BIT_TGL1]);
  // main sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      addr_reg <= 21'h00_0000;
      data_reg <= 8'h00;
      rdat_reg <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      step <= 3'd0;
      nsteps <= 3'd0;
      first <= 8'h00;
      tout_seen <= 1'b0;
      poll_cnt <= 32'h0000_0000;
      kind <= 2'd0;
      cyc_start <= 1'b0;
      fl_reset_n <= 1'b1;
    end else begin
      cyc_start <= 1'b0;
      if (ph_wr && state == S_IDLE) begin
        if ({27'h000_0000, ph_addr} == `FPSH_REG_ADDR)
          addr_reg <= hwdata[20:0];
        if ({27'h000_0000, ph_addr} == `FPSH_REG_DATA)
          data_reg <= hwdata[7:0];
      end
      case (state)
        S_IDLE: begin
          if (ctrl_wr) begin
            done <= 1'b0;
            fail <= 1'b0;
            step <= 3'd0;
            tout_seen <= 1'b0;
            poll_cnt <= 32'h0000_0000;
            if (hwdata[`FPSH_CTRL_PROG]) begin
              kind <= 2'd0;
              nsteps <= 3'd3;
              busy <= 1'b1;
              state <= S_SEQ;
              cyc_start <= 1'b1;
            end else if (hwdata[`FPSH_CTRL_READ]) begin
              busy <= 1'b1;
              state <= S_DATA;
              cyc_start <= 1'b1;
            end else if (hwdata[`FPSH_CTRL_RST]) begin
              busy <= 1'b1;
              fl_reset_n <= 1'b0;
              step <= 3'd7;
              state <= S_HWRST;
            end else if (hwdata[`FPSH_CTRL_SUSP] |
                         hwdata[`FPSH_CTRL_RESM]) begin
              kind <= hwdata[`FPSH_CTRL_SUSP] ? 2'd2 : 2'd3;
              nsteps <= 3'd0;
              busy <= 1'b1;
              state <= S_SEQ;
              cyc_start <= 1'b1;
            end
          end
        end
        S_SEQ: if (cyc_done) begin
          if (step == nsteps) begin
            // poll only after the last strobe
            state <= (kind == 2'd0) ? S_POLL1 : S_IDLE;
            busy <= (kind == 2'd0);
            done <= (kind != 2'd0);
            cyc_start <= (kind == 2'd0);
          end else begin
            step <= step + 3'd1;
            cyc_start <= 1'b1;
          end
        end
        S_POLL1: if (cyc_done) begin
          // the first check opens with a double read; later checks compare against the previous read
          first <= cyc_rdata;
          state <= S_POLL2;
          cyc_start <= 1'b1;
        end
        S_POLL2: if (cyc_done) begin
          poll_cnt <= poll_cnt + 32'h0000_0001;
          if (tgl_same) begin
            state <= S_DATA;
            cyc_start <= 1'b1;
          end else if (tout_seen || poll_cnt == POLL_MAX) begin
            fail <= 1'b1;
            state <= S_RST;
            cyc_start <= 1'b1;
          end else begin
            tout_seen <= cyc_rdata[`FPSH_BIT_TOUT];
            first <= cyc_rdata;
            cyc_start <= 1'b1;
          end
        end
        S_DATA: if (cyc_done) begin
          // data from a read after completion
          rdat_reg <= cyc_rdata;
          busy <= 1'b0;
          done <= 1'b1;
          state <= S_IDLE;
        end
        S_RST: if (cyc_done) begin
          busy <= 1'b0;
          done <= 1'b1;
          state <= S_IDLE;
        end
        S_HWRST: begin
          step <= step - 3'd1;
          if (step == 3'd0) begin
            fl_reset_n <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

//--- fpsh_ctrl_assertions.sv
// port assertions for the flash host controller
`timescale 1ns/100ps
module fpsh_ctrl_assertions (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus answer
  input wire hreadyout,
  input wire hresp,
  // flash pins
  input wire [20:0] fl_addr,
  input wire fl_ce_n,
  input wire fl_we_n,
  input wire fl_oe_n,
  input wire fl_dq_oe,
  input wire fl_reset_n
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // bus always answers at once and okay
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  // write strobe only with chip enable and data driven
  chk_we_framed: assert property (!fl_we_n |->
    !fl_ce_n && fl_oe_n && fl_dq_oe)
    else $error("write strobe outside a write frame");
  // reads never drive the data lines
  chk_oe_framed: assert property (!fl_oe_n |->
    !fl_ce_n && !fl_dq_oe)
    else $error("read strobe outside a read frame");
  // strobe phases are five clocks long
  chk_we_width: assert property ($fell(fl_we_n) |->
    !fl_we_n [*5] ##1 fl_we_n)
    else $error("write strobe width wrong");
  chk_oe_width: assert property ($fell(fl_oe_n) |->
    !fl_oe_n [*5] ##1 fl_oe_n)
    else $error("read strobe width wrong");
  // hardware reset pulse is eight clocks
  chk_rst_pulse: assert property ($fell(fl_reset_n) |->
    !fl_reset_n [*8] ##1 fl_reset_n)
    else $error("flash reset pulse width wrong");
  // address held while selected
  chk_addr_hold: assert property (!fl_ce_n && !$past(fl_ce_n)
    |-> $stable(fl_addr))
    else $error("address moved inside a cycle");
  // each cycle is a separate access
  chk_ce_gap: assert property ($rose(fl_ce_n) |->
    fl_ce_n [*5])
    else $error("chip enable gap too short");
  cov_write: cover property ($fell(fl_we_n));
  cov_read: cover property ($fell(fl_oe_n));
  cov_hw_rst: cover property ($fell(fl_reset_n));
endmodule
bind fpsh_ctrl fpsh_ctrl_assertions u_chk (.hclk, .hresetn,
  .hreadyout, .hresp, .fl_addr, .fl_ce_n, .fl_we_n, .fl_oe_n,
  .fl_dq_oe, .fl_reset_n);

//--- fpsh_flash_model.sv
// behavioural flash device: program, status bits, resets
`timescale 1ns/100ps
`include "fpsh_consts.vh"
module fpsh_flash_model #(
  parameter PROG_NS = 3000,
  parameter PROT_NS = 1500
) (
  // flash pins
  input wire [20:0] fl_addr,
  input wire fl_ce_n,
  input wire fl_we_n,
  input wire fl_oe_n,
  input wire [7:0] fl_dq_out,
  input wire fl_reset_n,
  output wire [7:0] fl_dq_in,
  output wire ready_busy_n,
  // fault controls
  input wire prot,
  input wire stuck,
  // erase driven by the bench
  input wire erase
);
  reg [7:0] mem [0:15];
  reg [7:0] rd;
  reg [7:0] pd;
  reg [3:0] pa;
  reg busy, tout, tgl, pr, ers, susp, t2;
  integer step, gen, i;
  initial begin
    for (i = 0; i < 16; i = i + 1)
      mem[i] = 8'hff;
    {busy, tout, tgl, pr, ers, susp, t2, pa, pd, rd} = 0;
    step = 0;
    gen = 0;
  end
  // released lines show the inverse of the last value
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd : ~rd;
  // open drain, pulled up when ready
  assign ready_busy_n = (busy || (ers && !susp)) ? 1'b0 : 1'b1;
  // run the algorithm, protected cells untouched
  task automatic run(input integer g);
    begin
      #(pr ? PROT_NS : PROG_NS);
      if (g == gen && stuck)
        tout = 1;
      else if (g == gen) begin
        if (!pr)
          mem[pa] = mem[pa] & pd;
        busy = 0;
      end
    end
  endtask
  always @(posedge fl_we_n) begin
    if (!fl_ce_n && fl_dq_out == `FPSH_CMD_RST && (!busy || tout)) begin
      step = 0;
      busy = 0;
      tout = 0;
      gen = gen + 1;
    end else if (!fl_ce_n && !busy && ers &&
                 fl_dq_out == `FPSH_CMD_SUSP) begin
      susp = 1;
    end else if (!fl_ce_n && !busy && susp &&
                 fl_dq_out == `FPSH_CMD_RESM) begin
      // resume only after an accepted suspend
      susp = 0;
    end else if (!fl_ce_n && !busy) begin
      case (step)
        0: step = (fl_addr == `FPSH_UNLOCK_A1 && fl_dq_out == 8'haa);
        1: step = (fl_addr == `FPSH_UNLOCK_A2 && fl_dq_out == 8'h55) * 2;
        2: step = (fl_addr == `FPSH_UNLOCK_A1 && fl_dq_out == 8'ha0) * 3;
        default: begin
          pa = fl_addr[3:0];
          pd = fl_dq_out;
          step = 0;
          busy = 1;
          pr = prot;
          gen = gen + 1;
          fork
            run(gen);
          join_none
        end
      endcase
    end
  end
  always @(negedge fl_reset_n) begin
    step = 0;
    busy = 0;
    tout = 0;
    gen = gen + 1;
  end
  // bench-driven erase; an all-protected one ends alone
  always @(posedge erase) begin
    ers = 1;
    susp = 0;
    if (prot) begin
      #(PROT_NS);
      ers = 0;
    end
  end
  always @(negedge erase) begin
    ers = 0;
    susp = 0;
  end
  // status while busy or erasing, array data otherwise
  always @(negedge fl_oe_n) begin
    if (!fl_ce_n && busy) begin
      tgl = ~tgl;
      rd = {~pd[7], tgl, tout, 5'h00};
    end else if (!fl_ce_n && ers) begin
      // every address counts as an erase sector
      tgl = susp ? tgl : ~tgl;
      t2 = ~t2;
      rd = {susp, tgl, 3'b000, t2, 2'b00};
    end else if (!fl_ce_n)
      rd = mem[fl_addr[3:0]];
  end
endmodule

//--- fpsh_ctrl_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/100ps
`include "fpsh_consts.vh"
module fpsh_ctrl_tb;
  reg hclk, hresetn, hsel, hwrite, prot, stuck, erase;
  reg [31:0] haddr, hwdata, rd, v;
  reg [1:0] htrans;
  reg [2:0] hsize;
  wire hreadyout, hresp, fl_ce_n, fl_we_n, fl_oe_n;
  wire fl_dq_oe, fl_reset_n, ready_busy_n;
  wire [31:0] hrdata;
  wire [20:0] fl_addr;
  wire [7:0] fl_dq_in, fl_dq_out;
  integer bad_count, check_count, n;
  fpsh_ctrl #(.POLL_MAX(64)) uut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .fl_addr, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_dq_in,
    .fl_dq_out, .fl_dq_oe, .fl_reset_n, .ready_busy_n);
  fpsh_flash_model fm (.fl_addr, .fl_ce_n, .fl_we_n, .fl_oe_n,
    .fl_dq_out, .fl_reset_n, .fl_dq_in, .ready_busy_n, .prot, .stuck,
    .erase);
  // one single-word transfer, entered just after an edge
  task ahb(input w, input [31:0] a, d, output [31:0] r);
    begin
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
    end
  endtask
  task wr(input [31:0] a, d);
    ahb(1'b1, a, d, rd);
  endtask
  // read, mask and compare
  task rdc(input [31:0] a, m, e);
    begin
      ahb(1'b0, a, 32'h0000_0000, rd);
      check_count = check_count + 1;
      if ((rd & m) !== e) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rd & m, e);
      end
    end
  endtask
  // start an operation and wait for busy to rise and clear
  task op(input [31:0] c);
    begin
      wr(`FPSH_REG_CTRL, c);
      rd = 32'h0000_0000;
      for (n = 0; n < 10 && rd[0] !== 1'b1; n = n + 1)
        ahb(1'b0, `FPSH_REG_STAT, 32'h0000_0000, rd);
      for (n = 0; n < 4000 && rd[0] !== 1'b0; n = n + 1)
        ahb(1'b0, `FPSH_REG_STAT, 32'h0000_0000, rd);
      if (n == 4000) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rd,
          32'h0000_0000);
      end
    end
  endtask
  task prog(input [20:0] a, input [7:0] d);
    begin
      wr(`FPSH_REG_ADDR, {11'h000, a});
      wr(`FPSH_REG_DATA, {24'h00_0000, d});
      op(32'h0000_0001);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    hclk = 0;
    forever #10 hclk = ~hclk;
  end
  // hang guard
  initial begin
    #1_000_000;
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    {hresetn, hwrite, prot, stuck, erase, haddr, hwdata, htrans} = 0;
    hsel = 1;
    hsize = 3'b010;
    bad_count = 0;
    check_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    rdc(`FPSH_REG_STAT, 32'h0000_000f, 32'h0000_0008);
    rdc(32'h0000_0020, 32'hffff_ffff, 32'h0000_0000);
    $display("test idle done");
    prog(21'h00_0003, 8'h5a);
    rdc(`FPSH_REG_STAT, 32'h0000_000f, 32'h0000_000a);
    rdc(`FPSH_REG_RDAT, 32'h0000_00ff, 32'h0000_005a);
    prog(21'h1f_0004, 8'h0f);
    rdc(`FPSH_REG_RDAT, 32'h0000_00ff, 32'h0000_000f);
    prog(21'h00_0003, 8'ha5);
    rdc(`FPSH_REG_RDAT, 32'h0000_00ff, 8'h5a & 8'ha5);
    $display("test program done");
    prot <= 1;
    prog(21'h1f_0004, 8'h00);
    rdc(`FPSH_REG_RDAT, 32'h0000_00ff, 32'h0000_000f);
    prot <= 0;
    $display("test protected done");
    stuck <= 1;
    prog(21'h00_0005, 8'h11);
    rdc(`FPSH_REG_STAT, 32'h0000_0005, 32'h0000_0004);
    stuck <= 0;
    prog(21'h00_0005, 8'h11);
    rdc(`FPSH_REG_RDAT, 32'h0000_00ff, 32'h0000_0011);
    $display("test timeout done");
    op(32'h0000_0004);
    op(32'h0000_0008);
    op(32'h0000_0010);
    prog(21'h00_0006, 8'h3c);
    rdc(`FPSH_REG_RDAT, 32'h0000_00ff, 32'h0000_003c);
    wr(`FPSH_REG_ADDR, 32'h0000_0003);
    op(32'h0000_0002);
    rdc(`FPSH_REG_RDAT, 32'h0000_00ff, 8'h5a & 8'ha5);
    $display("test resets done");
    erase <= 1;
    wr(`FPSH_REG_ADDR, 32'h0000_0007);
    op(32'h0000_0002);
    ahb(1'b0, `FPSH_REG_RDAT, 32'h0000_0000, v);
    op(32'h0000_0002);
    rdc(`FPSH_REG_RDAT, 32'h0000_00c4, ~v & 32'h0000_0044);
    rdc(`FPSH_REG_STAT, 32'h0000_0008, 32'h0000_0000);
    op(32'h0000_0010);
    rdc(`FPSH_REG_STAT, 32'h0000_0008, 32'h0000_0000);
    op(32'h0000_0008);
    op(32'h0000_0002);
    ahb(1'b0, `FPSH_REG_RDAT, 32'h0000_0000, v);
    v = 32'h0000_0080 | (v & 32'h0000_0040) | (~v & 32'h0000_0004);
    op(32'h0000_0002);
    rdc(`FPSH_REG_RDAT, 32'h0000_00c4, v);
    rdc(`FPSH_REG_STAT, 32'h0000_0008, 32'h0000_0008);
    op(32'h0000_0010);
    op(32'h0000_0002);
    rdc(`FPSH_REG_RDAT, 32'h0000_0080, 32'h0000_0000);
    erase <= 0;
    @(posedge hclk);
    prot <= 1;
    erase <= 1;
    op(32'h0000_0002);
    rdc(`FPSH_REG_RDAT, 32'h0000_0080, 32'h0000_0000);
    repeat (100) @(posedge hclk);
    op(32'h0000_0002);
    rdc(`FPSH_REG_RDAT, 32'h0000_00ff, 32'h0000_00ff);
    erase <= 0;
    prot <= 0;
    $display("test erase done");
    final_report;
  end
endmodule
